// file: core/rsr_char_norm.sv
// Incoming character normaliser for one remote link.
// Assumes one character per valid cycle, synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module rsr_char_norm #(
    parameter rsr_pkg::rsr_link_t LINK = rsr_pkg::link_parallel
) (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] char_i,
    input wire logic valid_i,
    input wire logic eoi_i,
    output logic [6:0] char_o,
    output logic valid_o,
    output logic term_o
);
    import rsr_pkg::*;

    // Fold lower case onto upper case
    function automatic logic [6:0] to_upper(input logic [6:0] c);
        logic [6:0] r;
        r = c;
        if (c >= `RSR_CHAR_LOWER_A && c <= `RSR_CHAR_LOWER_Z) begin
            r[`RSR_CASE_BIT] = 1'b0;
        end
        return r;
    endfunction : to_upper

    logic [6:0] ascii;
    logic is_term;

    // Top data line dropped; everything is seven-bit text
    assign ascii = char_i[6:0];
    // Parallel: CR or any character under end-or-identify; serial: CR or LF
    assign is_term = (ascii == `RSR_CHAR_CR) ||
                     ((LINK == link_parallel) ? eoi_i : (ascii == `RSR_CHAR_LF));

    // Registered output so the parser sees clean data
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            char_o <= 7'h00;
            valid_o <= 1'b0;
            term_o <= 1'b0;
        end else begin
            valid_o <= valid_i;
            if (valid_i) begin
                char_o <= to_upper(ascii);
                term_o <= is_term;
            end
        end
    end

    a_norm_upper: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        valid_o |-> !(char_o >= `RSR_CHAR_LOWER_A && char_o <= `RSR_CHAR_LOWER_Z))
        else $error("lower case letter passed the normaliser");
    a_norm_cr_term: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        valid_i && char_i[6:0] == `RSR_CHAR_CR |=> valid_o && term_o)
        else $error("carriage return not flagged as terminator");

endmodule : rsr_char_norm

`default_nettype wire

// file: core/rsr_err_fifo.sv
// Sixteen entry error code queue with a registered read port.
// Assumes push is dropped when full and pop of an empty queue reads zero.
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module rsr_err_fifo (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    rsr_errq_if.queue q
);
    import rsr_pkg::*;

    logic [7:0] mem [`RSR_ERRQ_DEPTH];
    logic [`RSR_ERRQ_AW-1:0] wr_ptr;
    logic [`RSR_ERRQ_AW-1:0] rd_ptr;
    logic [`RSR_ERRQ_AW:0] count;
    logic do_push;
    logic do_pop;

    assign do_push = q.push && !q.full;
    assign do_pop = q.pop && !q.empty;
    assign q.empty = (count == '0);
    assign q.full = (count == (`RSR_ERRQ_AW+1)'(`RSR_ERRQ_DEPTH));

    // Storage; no reset so it maps onto plain memory
    always_ff @(posedge clock_i) begin
        if (do_push) begin
            mem[wr_ptr] <= q.push_data;
        end
    end

    // Pointers and fill count; overflow keeps the oldest codes
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + {4'h0, do_push} - {4'h0, do_pop};
        end
    end

    // Registered read data, loaded on pop, zero for a pop of an empty queue
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q.pop_data <= 8'h00;
        end else if (q.pop) begin
            q.pop_data <= do_pop ? mem[rd_ptr] : 8'h00;
        end
    end

    a_fifo_bound: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        count <= (`RSR_ERRQ_AW+1)'(`RSR_ERRQ_DEPTH))
        else $error("error queue holds more than sixteen codes");

endmodule : rsr_err_fifo

`default_nettype wire

// file: core/rsr_errq_if.sv
// Interface joining the status logic to its error code queue.
// Assumes one owner pushing and popping, one queue answering.
`timescale 1ns/1ps
`default_nettype none

interface rsr_errq_if;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic [7:0] pop_data;
    logic empty;
    logic full;

    modport owner (output push, output push_data, output pop,
                   input pop_data, input empty, input full);
    modport queue (input push, input push_data, input pop,
                   output pop_data, output empty, output full);
endinterface : rsr_errq_if

`default_nettype wire

// file: core/rsr_pkg.sv
// Types shared by the remote status reporting block.
// Assumes nothing of its surroundings.
package rsr_pkg;

    // Status commands decoded upstream by the command parser
    typedef enum logic [3:0] {
        cmd_none,
        cmd_read_stb,
        cmd_write_sre,
        cmd_read_sre,
        cmd_read_esr,
        cmd_write_ese,
        cmd_read_ese,
        cmd_clear_status,
        cmd_fetch_error
    } rsr_cmd_t;

    // Which remote link a character normaliser serves
    typedef enum logic {
        link_parallel,
        link_serial
    } rsr_link_t;

    // Transmit sequencer states
    typedef enum logic [2:0] {
        tx_idle,
        tx_body,
        tx_term,
        tx_srq_text
    } rsr_tx_state_t;

endpackage : rsr_pkg

// file: core/rsr_regs.svh
// Constants for the remote status reporting block: character codes,
// status bit positions, reset values and queue sizes.
// Assumes inclusion by bare name from any design file that needs it.
`ifndef RSR_REGS_SVH
`define RSR_REGS_SVH

// ****************************************************************
// Character codes
// ****************************************************************
`define RSR_CHAR_CR 7'h0d
`define RSR_CHAR_LF 7'h0a
`define RSR_CHAR_LOWER_A 7'h61
`define RSR_CHAR_LOWER_Z 7'h7a
`define RSR_CASE_BIT 5

// ****************************************************************
// Poll status byte and request enable mask bit positions
// ****************************************************************
`define RSR_STB_REQUEST 6
`define RSR_STB_EVENT_SUM 5
`define RSR_STB_MSG_AVAIL 4
`define RSR_STB_ERR_AVAIL 3
`define RSR_SRE_INSTR_SUM 0

// ****************************************************************
// Event status word
// ****************************************************************
`define RSR_ESR_CMD_ERROR 5
`define RSR_ESR_LIVE_MASK 8'hbd

// ****************************************************************
// Reset values
// ****************************************************************
`define RSR_STB_RESET 8'h00
`define RSR_SRE_RESET 8'h00
`define RSR_ESR_RESET 8'h00
`define RSR_ESE_RESET 8'h00

// ****************************************************************
// Error queue and service request text
// ****************************************************************
`define RSR_ERRQ_DEPTH 16
`define RSR_ERRQ_AW 4
`define RSR_SRQ_TEXT_MAX 3'h4

`endif

// file: core/rsr_top.sv
// Remote status reporting: incoming character normalising, response
// framing, poll status byte, enable masks, event status word, error queue.
// Assumes a command parser upstream issuing one status command per pulse.
//
// Summary of operation
// - Parallel responses end CR with end-or-identify
// - Parallel input: CR or EOI character terminates
// - Serial responses end with single CR
// - Serial input: CR or LF terminates
// - Drop top data bit, seven-bit text
// - Lower case folded to upper case
// - Error codes kept in sixteen-entry queue
// - Serial poll returns status byte, reset zero
// - Status byte bits 6,5,4,3 used; rest zero
// - Master summary: any enabled summary bit set
// - Event summary set when enabled event bits set
// - Error available while codes wait queued
// - Request bit on enabled rise drives service request
// - Poll, clear-status or summary low clear request
// - Master summary drops only with sources off
// - Status query reports master summary bit six
// - Request mask zero at reset, one enables
// - Status words read only, masks read/write
// - Serial link sends request text on request
// - Event word eight bits, cleared on read
// - Command error sets bit five, logs code
// - Message available follows output queue occupancy
// - Event enable mask gates event summary
`timescale 1ns/1ps
`default_nettype none
`include "rsr_regs.svh"

module rsr_top (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic link_serial_i,
    input wire logic [7:0] par_rx_char_i,
    input wire logic par_rx_valid_i,
    input wire logic par_rx_eoi_i,
    input wire logic [7:0] ser_rx_char_i,
    input wire logic ser_rx_valid_i,
    output logic [6:0] par_rx_char_o,
    output logic par_rx_valid_o,
    output logic par_rx_term_o,
    output logic [6:0] ser_rx_char_o,
    output logic ser_rx_valid_o,
    output logic ser_rx_term_o,
    input wire logic [6:0] resp_char_i,
    input wire logic resp_valid_i,
    input wire logic resp_last_i,
    output logic resp_ready_o,
    output logic [7:0] tx_char_o,
    output logic tx_valid_o,
    output logic tx_eoi_o,
    input wire logic tx_ready_i,
    input wire logic [31:0] srq_text_i,
    input wire logic [2:0] srq_text_len_i,
    input wire logic cmd_valid_i,
    input wire rsr_pkg::rsr_cmd_t cmd_i,
    input wire logic [7:0] cmd_data_i,
    output logic [15:0] query_data_o,
    output logic query_valid_o,
    input wire logic serial_poll_i,
    output logic [7:0] poll_byte_o,
    input wire logic cmd_error_i,
    input wire logic [7:0] error_code_i,
    input wire logic [7:0] event_set_i,
    input wire logic message_available_i,
    input wire logic instrument_summary_i,
    output logic srq_o
);
    import rsr_pkg::*;

    // ****************************************************************
    // Incoming character normalising, one per link
    // ****************************************************************
    rsr_char_norm #(.LINK(link_parallel)) u_par_norm (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .char_i(par_rx_char_i),
        .valid_i(par_rx_valid_i),
        .eoi_i(par_rx_eoi_i),
        .char_o(par_rx_char_o),
        .valid_o(par_rx_valid_o),
        .term_o(par_rx_term_o)
    );

    rsr_char_norm #(.LINK(link_serial)) u_ser_norm (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .char_i(ser_rx_char_i),
        .valid_i(ser_rx_valid_i),
        .eoi_i(1'b0),
        .char_o(ser_rx_char_o),
        .valid_o(ser_rx_valid_o),
        .term_o(ser_rx_term_o)
    );

    // ****************************************************************
    // Error code queue
    // ****************************************************************
    rsr_errq_if errq ();

    rsr_err_fifo u_errq (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .q(errq.queue)
    );

    logic cmd_take;
    logic fetch_pend;

    assign cmd_take = cmd_valid_i && (cmd_i != cmd_none);
    assign errq.push = cmd_error_i;
    assign errq.push_data = error_code_i;
    assign errq.pop = cmd_take && (cmd_i == cmd_fetch_error);

    // ****************************************************************
    // Status registers and summaries
    // ****************************************************************
    logic [7:0] request_enable_mask;
    logic [7:0] event_enable_register;
    logic [7:0] event_status_word;
    logic event_summary_bit;
    logic message_available_bit;
    logic error_available_bit;
    logic master_summary_bit;
    logic mss_q;
    logic request_bit;
    logic rqs_set;
    logic rqs_clr;
    logic clr_status;
    logic [7:0] esr_set;
    logic esr_clr;
    logic srq_pend;
    logic srq_text_done;

    // Build a status byte with a chosen value in the request slot
    function automatic logic [7:0] status_byte(input logic req, input logic e,
                                               input logic m, input logic a);
        logic [7:0] b;
        b = 8'h00;
        b[`RSR_STB_REQUEST] = req;
        b[`RSR_STB_EVENT_SUM] = e;
        b[`RSR_STB_MSG_AVAIL] = m;
        b[`RSR_STB_ERR_AVAIL] = a;
        return b;
    endfunction : status_byte

    assign clr_status = cmd_take && (cmd_i == cmd_clear_status);
    assign event_summary_bit = |(event_status_word & event_enable_register);
    assign message_available_bit = message_available_i;
    assign error_available_bit = !errq.empty;
    // Summary of every masked source; the instrument summary has its own enable
    assign master_summary_bit = |(status_byte(1'b0, event_summary_bit, message_available_bit, error_available_bit) & request_enable_mask) ||
                 (instrument_summary_i && request_enable_mask[`RSR_SRE_INSTR_SUM]);
    assign rqs_set = master_summary_bit && !mss_q;
    assign rqs_clr = serial_poll_i || clr_status || !master_summary_bit;
    assign srq_o = request_bit;

    // Masks: written by command only, cleared at reset
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            request_enable_mask <= `RSR_SRE_RESET;
            event_enable_register <= `RSR_ESE_RESET;
        end else if (cmd_take) begin
            if (cmd_i == cmd_write_sre) begin
                request_enable_mask <= cmd_data_i;
            end
            if (cmd_i == cmd_write_ese) begin
                event_enable_register <= cmd_data_i;
            end
        end
    end

    // Event word: a new event in the clearing cycle survives the clear
    assign esr_set = (event_set_i & `RSR_ESR_LIVE_MASK) |
                     ({7'h00, cmd_error_i} << `RSR_ESR_CMD_ERROR);
    assign esr_clr = clr_status || (cmd_take && cmd_i == cmd_read_esr);

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            event_status_word <= `RSR_ESR_RESET;
        end else begin
            event_status_word <= esr_set | (event_status_word & ~{8{esr_clr}});
        end
    end

    // Request bit: raised on a rising summary, set wins over any clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mss_q <= 1'b0;
            request_bit <= 1'b0;
        end else begin
            mss_q <= master_summary_bit;
            request_bit <= rqs_set || (request_bit && !rqs_clr);
        end
    end

    // Serial poll answer holds the request bit as it stood before the clear
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            poll_byte_o <= `RSR_STB_RESET;
        end else if (serial_poll_i) begin
            poll_byte_o <= status_byte(request_bit, event_summary_bit, message_available_bit, error_available_bit);
        end
    end

    // Pending request text for the serial link
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            srq_pend <= 1'b0;
        end else begin
            srq_pend <= (rqs_set && link_serial_i) || (srq_pend && !srq_text_done);
        end
    end

    // ****************************************************************
    // Query answers
    // ****************************************************************
    // Fetches wait one cycle for the queue's registered read data
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fetch_pend <= 1'b0;
            query_data_o <= 16'h0000;
            query_valid_o <= 1'b0;
        end else begin
            fetch_pend <= errq.pop;
            query_valid_o <= 1'b0;
            if (fetch_pend) begin
                query_data_o <= {8'h00, errq.pop_data};
                query_valid_o <= 1'b1;
            end else if (cmd_take) begin
                query_valid_o <= (cmd_i == cmd_read_stb) || (cmd_i == cmd_read_sre) ||
                                 (cmd_i == cmd_read_esr) || (cmd_i == cmd_read_ese);
                unique case (cmd_i)
                    cmd_read_stb: query_data_o <= {8'h00, status_byte(master_summary_bit, event_summary_bit, message_available_bit, error_available_bit)};
                    cmd_read_sre: query_data_o <= {8'h00, request_enable_mask};
                    cmd_read_esr: query_data_o <= {8'h00, event_status_word};
                    cmd_read_ese: query_data_o <= {8'h00, event_enable_register};
                    default: query_data_o <= query_data_o;
                endcase
            end
        end
    end

    // ****************************************************************
    // Response framing
    // ****************************************************************
    rsr_tx_state_t state;
    logic [2:0] text_idx;
    logic slot_free;

    assign slot_free = !tx_valid_o || tx_ready_i;
    assign resp_ready_o = slot_free && (state == tx_body ||
                          (state == tx_idle && !(srq_pend && link_serial_i)));
    assign srq_text_done = (state == tx_srq_text) && slot_free &&
                           (text_idx >= srq_text_len_i || text_idx >= `RSR_SRQ_TEXT_MAX);

    // Request text goes out between messages, never inside one
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= tx_idle;
            text_idx <= 3'h0;
            tx_char_o <= 8'h00;
            tx_valid_o <= 1'b0;
            tx_eoi_o <= 1'b0;
        end else if (slot_free) begin
            tx_valid_o <= 1'b0;
            tx_eoi_o <= 1'b0;
            unique case (state)
                tx_idle, tx_body: begin
                    if (state == tx_idle && srq_pend && link_serial_i) begin
                        state <= tx_srq_text;
                        text_idx <= 3'h0;
                    end else if (resp_valid_i) begin
                        tx_char_o <= {1'b0, resp_char_i};
                        tx_valid_o <= 1'b1;
                        state <= resp_last_i ? tx_term : tx_body;
                    end
                end
                tx_term: begin
                    tx_char_o <= {1'b0, `RSR_CHAR_CR};
                    tx_valid_o <= 1'b1;
                    tx_eoi_o <= !link_serial_i;
                    state <= tx_idle;
                end
                tx_srq_text: begin
                    tx_valid_o <= 1'b1;
                    if (srq_text_done) begin
                        tx_char_o <= {1'b0, `RSR_CHAR_CR};
                        state <= tx_idle;
                    end else begin
                        tx_char_o <= {1'b0, srq_text_i[{text_idx[1:0], 3'b000} +: 7]};
                        text_idx <= text_idx + 3'h1;
                    end
                end
                default: state <= tx_idle;
            endcase
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_last_taken;
        resp_valid_i && resp_ready_o && resp_last_i;
    endsequence

    sequence s_last_sent;
        tx_valid_o && tx_ready_i;
    endsequence

    a_resp_ends_cr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        s_last_taken ##1 s_last_sent |=> tx_valid_o && tx_char_o[6:0] == `RSR_CHAR_CR)
        else $error("response not followed by carriage return");
    a_eoi_on_cr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        tx_valid_o && tx_eoi_o |-> tx_char_o[6:0] == `RSR_CHAR_CR && !link_serial_i)
        else $error("end-or-identify on a non-terminator");
    a_rqs_on_rise: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $rose(master_summary_bit) |=> srq_o)
        else $error("service request missing after summary rose");
    a_poll_clears: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        serial_poll_i && !rqs_set |=> !srq_o)
        else $error("service request survived serial poll");
    a_mss_low_clear: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        !master_summary_bit |=> !request_bit)
        else $error("request bit held without summary");
    a_poll_byte_form: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        $past(serial_poll_i) |-> poll_byte_o[7] == 1'b0 && poll_byte_o[2:0] == 3'b000
            && poll_byte_o[`RSR_STB_REQUEST] == $past(request_bit))
        else $error("poll byte malformed");
    a_esr_read_clr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_take && cmd_i == cmd_read_esr && esr_set == 8'h00 |=> event_status_word == 8'h00)
        else $error("event word not cleared on read");
    a_cme_logged: assert property (@(posedge clock_i) disable iff (sys_rst_i)
        cmd_error_i |=> event_status_word[`RSR_ESR_CMD_ERROR] && error_available_bit)
        else $error("command error not recorded");

endmodule : rsr_top

`default_nettype wire

// file: testbench/rsr_host_model.sv
// Far-side host model: sinks response characters from the block.
// Assumes the tx handshake is sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rsr_host_model (
    input wire logic clock_i,
    input wire logic stall_i,
    input wire logic [7:0] tx_char_i,
    input wire logic tx_valid_i,
    input wire logic tx_eoi_i,
    output logic tx_ready_o
);
    logic [8:0] got [0:7];
    int n_got = 0;
    // Ready drops only on request, to hold the block's slot busy
    assign tx_ready_o = !stall_i;
    // Log each accepted character with its end flag on top
    always @(posedge clock_i) begin
        if (tx_valid_i && tx_ready_o) begin
            got[n_got[2:0]] <= {tx_eoi_i, tx_char_i};
            n_got <= n_got + 1;
        end
    end
endmodule : rsr_host_model
`default_nettype wire

// file: testbench/tb_remote_status_reporting.sv
// Self-checking bench for the remote status reporting block.
// Assumes rsr_top and the host model; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb_remote_status_reporting;
    import rsr_pkg::*;
    logic clock_i = 0, sys_rst_i = 1, link_serial_i = 0, stall = 0;
    logic [7:0] par_rx_char_i = 0, ser_rx_char_i = 0, cmd_data_i = 0;
    logic par_rx_valid_i = 0, par_rx_eoi_i = 0, ser_rx_valid_i = 0;
    logic [6:0] resp_char_i = 0, par_rx_char_o, ser_rx_char_o;
    logic resp_valid_i = 0, resp_last_i = 0, cmd_valid_i = 0;
    logic serial_poll_i = 0, cmd_error_i = 0, tx_ready_i;
    logic message_available_i = 0, instrument_summary_i = 0;
    logic [7:0] error_code_i = 0, tx_char_o, poll_byte_o, event_set_i = 0;
    logic par_rx_valid_o, par_rx_term_o, ser_rx_valid_o, ser_rx_term_o;
    logic resp_ready_o, tx_valid_o, tx_eoi_o, query_valid_o, srq_o;
    logic [15:0] query_data_o;
    rsr_cmd_t cmd_i = cmd_none;
    int bad_count = 0, n_compared = 0;
    always #12.5 clock_i = ~clock_i;
    rsr_top dut (.clock_i, .sys_rst_i, .link_serial_i, .par_rx_char_i,
        .par_rx_valid_i, .par_rx_eoi_i, .ser_rx_char_i, .ser_rx_valid_i,
        .par_rx_char_o, .par_rx_valid_o, .par_rx_term_o, .ser_rx_char_o,
        .ser_rx_valid_o, .ser_rx_term_o, .resp_char_i, .resp_valid_i,
        .resp_last_i, .resp_ready_o, .tx_char_o, .tx_valid_o, .tx_eoi_o,
        .tx_ready_i, .srq_text_i(32'h51), .srq_text_len_i(3'h1),
        .cmd_valid_i, .cmd_i, .cmd_data_i, .query_data_o, .query_valid_o,
        .serial_poll_i, .poll_byte_o, .cmd_error_i, .error_code_i,
        .event_set_i, .message_available_i, .instrument_summary_i, .srq_o);
    rsr_host_model host (.clock_i, .stall_i(stall), .tx_char_i(tx_char_o),
        .tx_valid_i(tx_valid_o), .tx_eoi_i(tx_eoi_o), .tx_ready_o(tx_ready_i));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("compared %0d, wrong %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    // One character on one link; outputs are settled on return
    task automatic rx(input logic [7:0] c, input logic e, input logic s);
        @(negedge clock_i);
        par_rx_char_i = c;
        ser_rx_char_i = c;
        par_rx_eoi_i = e;
        par_rx_valid_i = !s;
        ser_rx_valid_i = s;
        @(negedge clock_i);
        par_rx_valid_i = 0;
        ser_rx_valid_i = 0;
    endtask : rx
    task automatic cmdx(input rsr_cmd_t c, input logic [7:0] d);
        @(negedge clock_i);
        cmd_valid_i = 1;
        cmd_i = c;
        cmd_data_i = d;
        @(negedge clock_i);
        cmd_valid_i = 0;
    endtask : cmdx
    task automatic q(input rsr_cmd_t c, input logic [15:0] exp);
        cmdx(c, 8'h00);
        chk({query_valid_o, query_data_o}, {1'b1, exp});
    endtask : q
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_rx;
        rx(8'he1, 0, 0);
        chk({par_rx_valid_o, par_rx_char_o, par_rx_term_o}, 9'h182);
        rx(8'h8d, 0, 0);
        chk(par_rx_term_o, 1);
        rx(8'h58, 1, 0);
        chk({par_rx_char_o, par_rx_term_o}, 8'hb1);
        rx(8'h0a, 0, 0);
        chk(par_rx_term_o, 0);
        rx(8'h0a, 0, 1);
        chk({ser_rx_valid_o, ser_rx_char_o, ser_rx_term_o}, 9'h115);
        rx(8'hfa, 0, 1);
        chk({ser_rx_char_o, ser_rx_term_o}, 8'hb4);
        rx(8'h0d, 0, 1);
        chk(ser_rx_term_o, 1);
    endtask : test_rx
    // One-character response; the host stalls before taking it
    task automatic test_tx(input logic s);
        int b;
        b = host.n_got;
        link_serial_i = s;
        stall = 1;
        @(negedge clock_i);
        resp_valid_i = 1;
        resp_char_i = 7'h42;
        resp_last_i = 1;
        @(negedge clock_i);
        resp_valid_i = 0;
        repeat (3) @(negedge clock_i);
        chk({tx_valid_o, tx_char_o}, 9'h142);
        chk(resp_ready_o, 0);
        stall = 0;
        repeat (4) @(negedge clock_i);
        chk(host.got[b], 9'h042);
        chk(host.got[b + 1], {!s, 8'h0d});
        chk(host.n_got, b + 2);
    endtask : test_tx
    task automatic test_status;
        q(cmd_read_stb, 16'h0000);
        q(cmd_read_sre, 16'h0000);
        cmdx(cmd_write_ese, 8'h20);
        cmdx(cmd_write_sre, 8'h20);
        q(cmd_read_sre, 16'h0020);
        q(cmd_read_ese, 16'h0020);
        @(negedge clock_i);
        cmd_error_i = 1;
        error_code_i = 8'h42;
        @(negedge clock_i);
        cmd_error_i = 0;
        repeat (3) @(negedge clock_i);
        chk(srq_o, 1);
        q(cmd_read_stb, 16'h0068);
        repeat (8) @(negedge clock_i);
        chk({host.got[4], host.got[5]}, {9'h051, 9'h00d});
        // Controller answers the request with a serial poll
        serial_poll_i = 1;
        @(negedge clock_i);
        serial_poll_i = 0;
        chk({poll_byte_o, srq_o}, 9'h0d0);
        q(cmd_read_esr, 16'h0020);
        q(cmd_read_esr, 16'h0000);
        q(cmd_read_stb, 16'h0008);
        cmdx(cmd_fetch_error, 8'h00);
        @(negedge clock_i);
        chk({query_valid_o, query_data_o}, 17'h10042);
        q(cmd_read_stb, 16'h0000);
    endtask : test_status
    // Summary sources other than errors; parallel link so no text is queued
    task automatic test_summary;
        link_serial_i = 0;
        message_available_i = 1;
        q(cmd_read_stb, 16'h0010);
        cmdx(cmd_write_sre, 8'h11);
        @(negedge clock_i);
        chk(srq_o, 1);
        q(cmd_read_stb, 16'h0050);
        message_available_i = 0;
        @(negedge clock_i);
        chk(srq_o, 0);
        instrument_summary_i = 1;
        @(negedge clock_i);
        chk(srq_o, 1);
        cmdx(cmd_clear_status, 8'h00);
        chk(srq_o, 0);
        instrument_summary_i = 0;
        event_set_i = 8'hff;
        @(negedge clock_i);
        event_set_i = 8'h00;
        q(cmd_read_stb, 16'h0020);
        cmdx(cmd_write_ese, 8'h00);
        q(cmd_read_stb, 16'h0000);
        q(cmd_read_esr, 16'h00bd);
    endtask : test_summary
    initial begin
        repeat (5) @(negedge clock_i);
        sys_rst_i = 0;
        test_rx();
        test_tx(0);
        test_tx(1);
        test_status();
        test_summary();
        report_and_stop();
    end
    // Watchdog well beyond the hundred or so cycles the run needs
    initial begin
        #100us;
        bad_count++;
        report_and_stop();
    end
endmodule : tb_remote_status_reporting
`default_nettype wire
